//--- logic/wcc_pkg.sv
// Constants, types and register map of the write CRC checker
package wcc_pkg;
  // ==========================================
  // Clock and timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ALERT_LAT_NS = 13;
  localparam int ALERT_LAT_RAW = (ALERT_LAT_NS * 1000) / CLK_PERIOD_PS;
  localparam int ALERT_LAT_CYC = (ALERT_LAT_RAW < 1) ? 1 : ALERT_LAT_RAW;
  localparam int ALERT_PW_MIN = 6;
  localparam int ALERT_PW_MAX = 10;
  localparam logic [3:0] ALERT_PW_CYC = 4'h8;
  // ==========================================
  // Frame layout
  localparam int WORD_BITS = 72;
  localparam int BEATS = 10;
  localparam logic [3:0] CRC_BEAT = 4'h8;
  localparam logic [3:0] LAST_BEAT = 4'h9;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // ==========================================
  // Register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MODE_REG_FIVE_OFS = 8'h04;
  localparam logic [7:0] MPR_THREE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam int CTRL_CRC_EN_BIT = 0;
  localparam int CTRL_INV_BIT = 1;
  localparam int CTRL_MASK_BIT = 2;
  localparam int MR5_CLEAR_BIT = 3;
  localparam int MULTIPURPOSE_PAGE_REG_THREE_STATUS_BIT = 7;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic upper_inversion_lane_n;
    logic lower_inversion_lane_n;
    logic [15:0] dq;
  } wcc_lanes_s;
  typedef struct packed {
    logic write_data_mask;
    logic write_data_inversion;
    logic crc_en;
  } wcc_cfg_s;
endpackage

//--- logic/wcc_write_crc_check.sv
// Write CRC checker with alert pulse and APB registers
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// ==========================================
module wcc_write_crc_check
  import wcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_frame,
  input wire logic data_strobe,
  input wire wcc_lanes_s lanes,
  input wire logic ca_parity_err,
  input wire logic alert_n_i,
  output logic alert_n_o,
  output logic alert_n_oe,
  output logic [127:0] core_wdata,
  output logic [15:0] core_wmask_n,
  output logic core_wvalid
);
  // ==========================================
  // Check function
  // Serial form of the tree: yields the same parallel equations
  function automatic logic [7:0] parallel_check_function(input logic [71:0] d);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    fb = 1'b0;
    for (int i = WORD_BITS - 1; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // Side lane of one half in one transfer
  function automatic logic side_lane(input wcc_lanes_s b, input logic h);
    return h ? b.upper_inversion_lane_n : b.lower_inversion_lane_n;
  endfunction

  // Gather one half of the frame into a 72-bit code word
  function automatic logic [71:0] half_word(
    input wcc_lanes_s b [BEATS],
    input logic h,
    input logic use_side
  );
    logic [71:0] w;
    w = '1;
    for (int t = 0; t < 8; t++) begin
      for (int l = 0; l < 8; l++) begin
        w[l*8+t] = b[t].dq[{h, 3'(l)}];
      end
      if (use_side) begin
        w[64+t] = side_lane(b[t], h);
      end
    end
    return w;
  endfunction

  // ==========================================
  // Pin synchronisers
  logic strobe_s1, strobe_s2, strobe_s3;
  logic frame_s1, frame_s2;
  wcc_lanes_s lanes_s1, lanes_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
      frame_s1 <= 1'b0;
      frame_s2 <= 1'b0;
      lanes_s1 <= '1;
      lanes_s2 <= '1;
    end else begin
      strobe_s1 <= data_strobe;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      frame_s1 <= write_frame;
      frame_s2 <= frame_s1;
      lanes_s1 <= lanes;
      lanes_s2 <= lanes_s1;
    end
  end

  logic strobe_edge;
  assign strobe_edge = strobe_s2 ^ strobe_s3;

  // ==========================================
  // Configuration and mode bits
  wcc_cfg_s cfg;
  logic mode_reg_five_clear;
  logic multipurpose_page_reg_three_status;
  logic [7:0] err_count;
  logic [7:0] last_calc_lo, last_calc_hi;
  logic apb_wr, apb_setup;
  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_setup = psel && !penable;

  // ==========================================
  // Frame capture
  wcc_lanes_s beat [BEATS];
  logic [3:0] beat_cnt;
  logic frame_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beat_cnt <= 4'h0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (!frame_s2 || !cfg.crc_en) begin
        beat_cnt <= 4'h0;
      end else if (strobe_edge) begin
        beat_cnt <= (beat_cnt == LAST_BEAT) ? 4'h0 : beat_cnt + 4'h1;
        frame_done <= (beat_cnt == LAST_BEAT);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < BEATS; i++) begin
        beat[i] <= '1;
      end
    end else if (frame_s2 && cfg.crc_en && strobe_edge) begin
      beat[beat_cnt] <= lanes_s2;
    end
  end

  // ==========================================
  // Two identical trees
  logic use_side;
  logic [71:0] word_lo, word_hi;
  logic [7:0] calc_lo, calc_hi, rx_lo, rx_hi;
  logic crc_err_det;

  // Mask and inversion share the side lane; both on is not expected
  assign use_side = cfg.write_data_inversion | cfg.write_data_mask;
  assign word_lo = half_word(beat, 1'b0, use_side);
  assign word_hi = half_word(beat, 1'b1, use_side);
  assign calc_lo = parallel_check_function(word_lo);
  assign calc_hi = parallel_check_function(word_hi);
  assign rx_lo = beat[CRC_BEAT].dq[7:0];
  assign rx_hi = beat[CRC_BEAT].dq[15:8];
  assign crc_err_det = frame_done && ((calc_lo != rx_lo) || (calc_hi != rx_hi));

  // ==========================================
  // Data to the core
  // Written at once; a bad frame is fixed by the host's retry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_wdata <= '0;
      core_wmask_n <= '1;
      core_wvalid <= 1'b0;
    end else begin
      core_wvalid <= frame_done;
      if (frame_done) begin
        for (int t = 0; t < 8; t++) begin
          for (int h = 0; h < 2; h++) begin
            core_wdata[t*16+h*8 +: 8] <= beat[t].dq[h*8 +: 8] ^
              {8{cfg.write_data_inversion && !side_lane(beat[t], h[0])}};
            core_wmask_n[t*2+h] <= cfg.write_data_mask ? side_lane(beat[t], h[0]) : 1'b1;
          end
        end
      end
    end
  end

  // ==========================================
  // Alert pulse
  logic [3:0] pw_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_cnt <= 4'h0;
      alert_n_oe <= 1'b0;
    end else if (crc_err_det || ca_parity_err) begin
      pw_cnt <= ALERT_PW_CYC - 4'h1;
      alert_n_oe <= 1'b1;
    end else if (pw_cnt != 4'h0) begin
      pw_cnt <= pw_cnt - 4'h1;
    end else begin
      alert_n_oe <= 1'b0;
    end
  end

  // Only ever pulls low, so devices can share the wire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_n_o <= 1'b0;
    end else begin
      alert_n_o <= 1'b0;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CTRL_RESET;
    end else if (apb_wr && paddr == CTRL_OFS) begin
      cfg <= pwdata[2:0];
    end
  end

  // Set beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg_five_clear <= 1'b0;
    end else if (crc_err_det) begin
      mode_reg_five_clear <= 1'b1;
    end else if (apb_wr && paddr == MODE_REG_FIVE_OFS) begin
      mode_reg_five_clear <= pwdata[MR5_CLEAR_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multipurpose_page_reg_three_status <= 1'b0;
    end else if (crc_err_det) begin
      multipurpose_page_reg_three_status <= 1'b1;
    end else if (apb_wr && paddr == MPR_THREE_OFS) begin
      multipurpose_page_reg_three_status <= pwdata[MULTIPURPOSE_PAGE_REG_THREE_STATUS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_count <= 8'h00;
      last_calc_lo <= 8'h00;
      last_calc_hi <= 8'h00;
    end else if (frame_done) begin
      last_calc_lo <= calc_lo;
      last_calc_hi <= calc_hi;
      if (crc_err_det && err_count != 8'hff) begin
        err_count <= err_count + 8'h01;
      end
    end
  end

  // Zero-wait slave: answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (apb_setup) begin
        unique case (paddr)
          CTRL_OFS: prdata <= {29'h0, cfg};
          MODE_REG_FIVE_OFS: prdata <= 32'(mode_reg_five_clear) << MR5_CLEAR_BIT;
          MPR_THREE_OFS: prdata <= 32'(multipurpose_page_reg_three_status) << MULTIPURPOSE_PAGE_REG_THREE_STATUS_BIT;
          STATUS_OFS: prdata <= {8'h00, err_count, last_calc_hi, last_calc_lo};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================
  // Checks
  logic prev_det;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_det <= 1'b0;
    end else begin
      prev_det <= crc_err_det | ca_parity_err;
    end
  end

  alert_pw_min_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(alert_n_oe) |-> alert_n_oe [*6])
    else $error("alert pulse shorter than six cycles");
  alert_pw_max_a: assert property (@(posedge pclk) disable iff (!presetn)
    (alert_n_oe && !crc_err_det && !ca_parity_err && pw_cnt == 4'h0) |=> !alert_n_oe)
    else $error("alert pulse not released");
  alert_latency_a: assert property (@(posedge pclk) disable iff (!presetn)
    crc_err_det |=> alert_n_oe && pw_cnt == 4'h7)
    else $error("alert late after crc error");
  parity_alert_a: assert property (@(posedge pclk) disable iff (!presetn)
    ca_parity_err |=> alert_n_oe)
    else $error("parity error not on alert");
  clear_bit_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    crc_err_det |=> mode_reg_five_clear && multipurpose_page_reg_three_status)
    else $error("error bits not set");
  clear_bit_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg_five_clear && !(apb_wr && paddr == MODE_REG_FIVE_OFS)) |=> mode_reg_five_clear)
    else $error("clear bit dropped without write");
  mismatch_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_done && calc_hi != rx_hi) |-> crc_err_det)
    else $error("upper mismatch not flagged");
  side_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
    !use_side |-> word_lo[71:64] == 8'hff && word_hi[71:64] == 8'hff)
    else $error("side lane bits not ones");
  no_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    frame_done |=> core_wvalid)
    else $error("core write waited");
  open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
    alert_n_o == 1'b0)
    else $error("alert driven high");
  alert_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    prev_det |-> alert_n_oe && pw_cnt == ALERT_PW_CYC - 4'h1)
    else $error("alert not restarted by new error");

  crc_err_c: cover property (@(posedge pclk) disable iff (!presetn) crc_err_det);
  clean_frame_c: cover property (@(posedge pclk) disable iff (!presetn)
    frame_done && !crc_err_det);
  parity_c: cover property (@(posedge pclk) disable iff (!presetn) ca_parity_err);
  host_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(mode_reg_five_clear));
endmodule

//--- testbench/wcc_ctrl_model.sv
// Controller-side model driving write frames onto the lanes
`timescale 1ns/1ps
module wcc_ctrl_model
  import wcc_pkg::*;
(
  input logic pclk,
  output logic write_frame,
  output logic data_strobe,
  output wcc_lanes_s lanes
);
  // ==========================================
  // Check bits
  function automatic logic [7:0] calc_chk(input logic [127:0] d, input logic [15:0] s,
      input logic u, input int h);
    logic [7:0] c;
    logic b;
    c = CRC_INIT;
    for (int i = 71; i >= 0; i--) begin
      b = (i > 63) ? (s[(i - 64) * 2 + h] | ~u) : d[(i % 8) * 16 + h * 8 + i / 8];
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction
  initial begin
    write_frame = 1'b0;
    data_strobe = 1'b0;
    lanes = '0;
  end
  // ==========================================
  // One frame
  // Strobe stands still between frames
  task automatic send(input logic [127:0] d, input logic [15:0] s, input logic u,
      input logic [15:0] cf, input logic [127:0] df);
    logic [15:0] c;
    c = {calc_chk(d, s, u, 1), calc_chk(d, s, u, 0)} ^ cf;
    @(posedge pclk);
    write_frame <= 1'b1;
    repeat (4) @(posedge pclk);
    for (int t = 0; t < 10; t++) begin
      if (t < 8) lanes <= {s[t * 2 + 1], s[t * 2], d[t * 16 +: 16] ^ df[t * 16 +: 16]};
      else if (t == 8) lanes <= {2'b11, c};
      else lanes <= {2'b11, 16'hffff};
      // Lanes settle three cycles ahead of the strobe edge
      repeat (3) @(posedge pclk);
      data_strobe <= ~data_strobe;
      @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    write_frame <= 1'b0;
    // Released lanes must not keep a stale value
    lanes <= ~lanes;
  endtask
endmodule

//--- testbench/wcc_tb_top.sv
// Self-checking testbench for the write CRC checker
`timescale 1ns/1ps
module write_crc_check_alert_tb_top
  import wcc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ca_parity_err;
  logic write_frame, data_strobe, alert_n_o, alert_n_oe, alert_wire, core_wvalid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [127:0] core_wdata;
  logic [15:0] core_wmask_n, gc;
  wcc_lanes_s lanes;
  int miscompares, checked, nerr;
  localparam logic [127:0] DAT = 128'h0123456789abcdeffedcba9876543210;
  localparam logic [15:0] SIDE = 16'ha5c3;
  localparam logic [127:0] ERRS [6] = '{128'h1, 128'h10001, 128'h700, {8{16'h0008}},
    {8{16'h1000}}, 128'h80008000};
  // Pull-up holds the shared line high when released
  assign alert_wire = alert_n_oe ? alert_n_o : 1'b1;
  wcc_ctrl_model p (.pclk, .write_frame, .data_strobe, .lanes);
  wcc_write_crc_check dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .write_frame, .data_strobe, .lanes, .ca_parity_err,
    .alert_n_i(alert_wire), .alert_n_o, .alert_n_oe, .core_wdata, .core_wmask_n,
    .core_wvalid);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================
  // Helpers
  task automatic end_sim();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      miscompares++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, a, d, v, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] v;
    logic e;
    apb(1'b0, a, 32'h0, v, e);
    chk(v, x);
    chk(e, xe);
  endtask
  // Bounded look at the alert pulse
  task automatic alert_meas(input logic exp);
    int lat;
    int w;
    lat = 0;
    w = 0;
    while (alert_n_oe !== 1'b1 && lat < 3) begin
      @(posedge pclk);
      lat++;
    end
    while (alert_n_oe === 1'b1 && w < 20) begin
      chk(alert_wire, 1'b0);
      @(posedge pclk);
      w++;
    end
    chk(w > 0, exp);
    if (exp) chk(lat > ALERT_LAT_CYC, 1'b0);
    if (exp) chk(w, ALERT_PW_CYC);
  endtask
  task automatic frame(input logic [2:0] cfg, input logic [15:0] cf, input logic [127:0] df,
      input logic xv, input logic exp);
    int n;
    logic [127:0] ed;
    ed = DAT ^ df;
    for (int i = 0; i < 16; i++) begin
      if (cfg[1] && !SIDE[i]) ed[i * 8 +: 8] = ~ed[i * 8 +: 8];
    end
    n = 0;
    fork
      p.send(DAT, SIDE, cfg[1] | cfg[2], cf, df);
      begin
        while (core_wvalid !== 1'b1 && n < 100) begin
          @(posedge pclk);
          n++;
        end
        chk(n < 100, xv);
        if (n == 100 && xv) end_sim();
        if (xv) alert_meas(exp);
      end
    join
    if (xv) begin
      chk(core_wdata, ed);
      chk(core_wmask_n, cfg[2] ? SIDE : 16'hffff);
    end
    nerr += exp;
    $display("frame test done cfg=%0h err=%0d", cfg, exp);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ca_parity_err = 1'b0;
    miscompares = 0;
    checked = 0;
    nerr = 0;
    gc = {p.calc_chk(DAT, SIDE, 1'b0, 1), p.calc_chk(DAT, SIDE, 1'b0, 0)};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 5; i++) rdc(8'(i * 4), 32'h0, i == 4);
    wr(CTRL_OFS, 32'hfffffffb);
    rdc(CTRL_OFS, 32'h3, 1'b0);
    wr(CTRL_OFS, 32'h1);
    $display("register test done");
    frame(3'h1, 16'h0, 128'h0, 1'b1, 1'b0);
    rdc(STATUS_OFS, {16'h0, gc}, 1'b0);
    for (int i = 0; i < 6; i++) frame(3'h1, 16'h0, ERRS[i], 1'b1, 1'b1);
    frame(3'h1, 16'h0001, 128'h0, 1'b1, 1'b1);
    frame(3'h1, 16'h8000, 128'h0, 1'b1, 1'b1);
    rdc(MODE_REG_FIVE_OFS, 32'h8, 1'b0);
    rdc(MPR_THREE_OFS, 32'h80, 1'b0);
    rdc(STATUS_OFS, {8'h0, 8'(nerr), gc}, 1'b0);
    frame(3'h1, 16'h0, 128'h0, 1'b1, 1'b0);
    rdc(MODE_REG_FIVE_OFS, 32'h8, 1'b0);
    wr(MODE_REG_FIVE_OFS, 32'h0);
    wr(MPR_THREE_OFS, 32'h0);
    rdc(MODE_REG_FIVE_OFS, 32'h0, 1'b0);
    rdc(MPR_THREE_OFS, 32'h0, 1'b0);
    $display("clear test done");
    wr(CTRL_OFS, 32'h3);
    frame(3'h3, 16'h0, 128'h0, 1'b1, 1'b0);
    wr(CTRL_OFS, 32'h5);
    frame(3'h5, 16'h0, 128'h0, 1'b1, 1'b0);
    wr(CTRL_OFS, 32'h0);
    frame(3'h0, 16'h1, 128'h0, 1'b0, 1'b0);
    @(posedge pclk);
    ca_parity_err <= 1'b1;
    @(posedge pclk);
    ca_parity_err <= 1'b0;
    alert_meas(1'b1);
    $display("parity test done");
    end_sim();
  end
endmodule
